// ---- rtl/thimc_pkg.sv ----
package thimc_pkg;

  // bus and protocol layout
  localparam int ADDR_W = 7;
  localparam logic [6:0] SLAVE_ADDR_RST = 7'h38; // arbitrary default address
  localparam int CFG_W = 8;
  localparam int NUM_CFG = 8;
  localparam int CFG_IDX_W = 3;
  localparam logic [2:0] CFG_IDX_RATE = 3'h0; // frame rate in Hz
  localparam logic [2:0] CFG_IDX_SLEEP = 3'h1; // bit 0 requests sleep
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h3C; // 60 frames per second
  localparam logic [7:0] RATE_MAX = 8'h78; // 120 frames per second

  // timing
  localparam int CLK_HZ = 50000000;
  localparam int INIT_US = 1000; // parameter initialisation time
  localparam int INIT_CYC = (CLK_HZ / 1000000) * INIT_US;
  localparam int REPORT_MAX_MS = 200; // latest first report
  localparam int IDLE_MS = 500; // no-touch time before monitor
  localparam int IDLE_CYC = (CLK_HZ / 1000) * IDLE_MS;
  localparam int CNT_W = 32;

  // power modes
  typedef enum logic [1:0] {
    THIMC_ACTIVE = 2'b00,
    THIMC_MONITOR = 2'b01,
    THIMC_SLEEP = 2'b10
  } thimc_mode_t;

  // serial engine states
  typedef enum logic [2:0] {
    THIMC_S_IDLE = 3'b000,
    THIMC_S_ADDR = 3'b001,
    THIMC_S_AACK = 3'b010,
    THIMC_S_WR = 3'b011,
    THIMC_S_WACK = 3'b100,
    THIMC_S_RD = 3'b101,
    THIMC_S_RACK = 3'b110
  } thimc_sstate_t;

  // configuration write towards the panel front end
  typedef struct packed {
    logic valid;
    logic [2:0] idx;
    logic [7:0] data;
  } thimc_cfg_wr_t;

endpackage : thimc_pkg

// ---- rtl/thimc_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// two flip-flop synchroniser for one pin
module thimc_sync (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic rst_val_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_ff;
  logic nxt_meta;
  logic q_ff;
  logic nxt_q;

  // next values
  always_comb begin
    nxt_meta = d_i;
    nxt_q = meta_ff;
  end

  // flops, reset to idle level of the pin
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= 1'b1;
      q_ff <= 1'b1;
    end else begin
      meta_ff <= nxt_meta;
      q_ff <= nxt_q;
    end
  end

  assign q_o = q_ff;
endmodule : thimc_sync
`default_nettype wire

// ---- rtl/thimc_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RULE_01 - active mode scans frames at a rate from 0 to 120 per second
// RULE_02 - host writes a new frame rate over the serial port; applied
// RULE_03 - monitor runs presence check only; touch returns to active at once
// RULE_04 - serial port closed in monitor mode; no data passes
// RULE_05 - sleep ignores all host activity except reset and interrupt line; code leaves sleep on reset only, interrupt line is an output
// RULE_06 - interrupt output goes low when new touch data is ready
// RULE_07 - host wakes the device from sleep by holding reset low
// RULE_08 - after reset release the device always enters active mode
// RULE_09 - serial port is slave only; never drives the bus clock
// RULE_10 - seven-bit address then direction bit, one read zero write
// RULE_11 - stop ends the packet and closes any transaction
// RULE_12 - repeated start ends current packet and starts a new one
// RULE_13 - bus clock up to 400 kbit per second accepted
// RULE_14 - host configuration bytes forwarded to panel front end control
// RULE_15 - after reset signal interrupt once initialised, then report touches
// RULE_16 - first touch report within 200 ms of reset release
// RULE_17 - other agents keep off the bus while device held in reset
// RULE_18 - interrupt released once host has read pending touch data
// RULE_19 - no touch for a set period moves active to monitor
module thimc_ctrl import thimc_pkg::*; #(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int IDLE_CYCLES = IDLE_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic host_reset_wake_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic int_n_o,
  input wire logic frame_done_i,
  input wire logic touch_valid_i,
  input wire logic [7:0] touch_byte_i,
  input wire logic presence_i,
  output logic touch_rd_o,
  output logic [1:0] mode_o,
  output logic [7:0] frame_rate_o,
  output logic presence_only_o,
  output logic scan_en_o,
  output thimc_cfg_wr_t cfg_wr_o
);
  logic scl_s;
  logic sda_s;
  logic rstw_s;
  logic chip_rst;

  // pin synchronisers
  thimc_sync u_scl (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .rst_val_i(1'b1), .d_i(scl_i), .q_o(scl_s));
  thimc_sync u_sda (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .rst_val_i(1'b1), .d_i(sda_i), .q_o(sda_s));
  thimc_sync u_rstw (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .rst_val_i(1'b1), .d_i(host_reset_wake_n_i), .q_o(rstw_s));

  // host reset pin synchronously resets mode, timers, irq flags, engine state and config too
  assign chip_rst = ~rstw_s; // RULE_07

  // edge history of the synchronised bus lines
  logic scl_d_ff;
  logic sda_d_ff;
  logic nxt_scl_d;
  logic nxt_sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_comb begin
    nxt_scl_d = scl_s;
    nxt_sda_d = sda_s;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= nxt_scl_d;
      sda_d_ff <= nxt_sda_d;
    end
  end

  // conditions; oversampling at 50 MHz covers 400 kHz
  assign scl_rise = scl_s & ~scl_d_ff; // RULE_13
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // power mode and timers
  thimc_mode_t mode_ff;
  thimc_mode_t nxt_mode;
  logic [CNT_W-1:0] init_cnt_ff;
  logic [CNT_W-1:0] nxt_init_cnt;
  logic init_done_ff;
  logic nxt_init_done;
  logic [CNT_W-1:0] idle_cnt_ff;
  logic [CNT_W-1:0] nxt_idle_cnt;
  logic sleep_req;
  logic port_open;

  // serial engine state
  thimc_sstate_t st_ff;
  thimc_sstate_t nxt_st;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [3:0] bit_ff;
  logic [3:0] nxt_bit;
  logic rd_ff;
  logic nxt_rd;
  logic first_ff;
  logic nxt_first;
  logic [2:0] idx_ff;
  logic [2:0] nxt_idx;
  logic drv_low_ff;
  logic nxt_drv_low;
  logic [7:0] cfg_ff [NUM_CFG];
  logic [7:0] nxt_cfg [NUM_CFG];
  thimc_cfg_wr_t cfg_wr_ff;
  thimc_cfg_wr_t nxt_cfg_wr;
  logic rd_byte_done;
  logic int_pend_ff;
  logic nxt_int_pend;
  logic init_int_ff;
  logic nxt_init_int;
  logic touch_rd_ff;
  logic nxt_touch_rd;

  assign sleep_req = cfg_ff[CFG_IDX_SLEEP][0];
  // monitor closes the port, sleep ignores it
  assign port_open = (mode_ff == THIMC_ACTIVE); // RULE_04 RULE_05

  // mode sequencing
  always_comb begin
    nxt_mode = mode_ff;
    nxt_init_cnt = init_cnt_ff;
    nxt_init_done = init_done_ff;
    nxt_idle_cnt = idle_cnt_ff;
    if (!init_done_ff) begin
      if (init_cnt_ff >= CNT_W'(INIT_CYCLES - 1)) begin
        nxt_init_done = 1'b1; // RULE_15 RULE_16
      end else begin
        nxt_init_cnt = init_cnt_ff + 1'b1;
      end
    end
    case (mode_ff)
      THIMC_ACTIVE: begin
        if (sleep_req) begin
          nxt_mode = THIMC_SLEEP;
        end else if (touch_valid_i || !init_done_ff) begin
          nxt_idle_cnt = '0;
        end else if (idle_cnt_ff >= CNT_W'(IDLE_CYCLES - 1)) begin
          nxt_mode = THIMC_MONITOR; // RULE_19
          nxt_idle_cnt = '0;
        end else begin
          nxt_idle_cnt = idle_cnt_ff + 1'b1;
        end
      end
      THIMC_MONITOR: begin
        if (presence_i) begin
          nxt_mode = THIMC_ACTIVE; // RULE_03
        end
      end
      THIMC_SLEEP: begin
        nxt_mode = THIMC_SLEEP; // RULE_05 only reset leaves
      end
      default: nxt_mode = THIMC_ACTIVE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_ff <= THIMC_ACTIVE; // RULE_08
      init_cnt_ff <= '0;
      init_done_ff <= 1'b0;
      idle_cnt_ff <= '0;
    end else if (chip_rst) begin
      mode_ff <= THIMC_ACTIVE; // RULE_07 RULE_08
      init_cnt_ff <= '0;
      init_done_ff <= 1'b0;
      idle_cnt_ff <= '0;
    end else begin
      mode_ff <= nxt_mode;
      init_cnt_ff <= nxt_init_cnt;
      init_done_ff <= nxt_init_done;
      idle_cnt_ff <= nxt_idle_cnt;
    end
  end

  // slave engine: address, write bytes, read touch bytes
  always_comb begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_bit = bit_ff;
    nxt_rd = rd_ff;
    nxt_first = first_ff;
    nxt_idx = idx_ff;
    nxt_drv_low = drv_low_ff;
    nxt_cfg = cfg_ff;
    nxt_cfg_wr = '0;
    nxt_touch_rd = 1'b0;
    rd_byte_done = 1'b0;
    if (!port_open || stop_det) begin
      nxt_st = THIMC_S_IDLE; // RULE_11 RULE_04
      nxt_drv_low = 1'b0;
    end else if (start_det) begin
      nxt_st = THIMC_S_ADDR; // RULE_12 restart begins new packet
      nxt_bit = 4'h0;
      nxt_drv_low = 1'b0;
    end else begin
      case (st_ff)
        THIMC_S_IDLE: nxt_drv_low = 1'b0;
        THIMC_S_ADDR: begin
          if (scl_rise) begin
            nxt_sh = {sh_ff[6:0], sda_s};
            nxt_bit = bit_ff + 4'h1;
          end else if (scl_fall && bit_ff == 4'h8) begin
            if (sh_ff[7:1] == SLAVE_ADDR_RST) begin // RULE_10
              nxt_rd = sh_ff[0]; // RULE_10 one means read
              nxt_drv_low = 1'b1;
              nxt_st = THIMC_S_AACK;
              nxt_first = 1'b1;
            end else begin
              nxt_st = THIMC_S_IDLE;
            end
          end
        end
        THIMC_S_AACK, THIMC_S_WACK: begin
          if (scl_fall) begin
            nxt_bit = 4'h0;
            nxt_drv_low = 1'b0;
            if (rd_ff) begin
              nxt_st = THIMC_S_RD;
              nxt_sh = touch_byte_i;
              nxt_drv_low = ~touch_byte_i[7];
              nxt_touch_rd = 1'b1;
            end else begin
              nxt_st = THIMC_S_WR;
            end
          end
        end
        THIMC_S_WR: begin
          if (scl_rise) begin
            nxt_sh = {sh_ff[6:0], sda_s};
            nxt_bit = bit_ff + 4'h1;
          end else if (scl_fall && bit_ff == 4'h8) begin
            nxt_drv_low = 1'b1;
            nxt_st = THIMC_S_WACK;
            if (first_ff) begin
              nxt_idx = sh_ff[2:0];
              nxt_first = 1'b0;
            end else begin
              nxt_cfg[idx_ff] = sh_ff; // RULE_02 RULE_14
              nxt_cfg_wr.valid = 1'b1; // RULE_14
              nxt_cfg_wr.idx = idx_ff;
              nxt_cfg_wr.data = sh_ff;
              nxt_idx = idx_ff + 3'h1;
            end
          end
        end
        THIMC_S_RD: begin
          if (scl_rise) begin
            nxt_bit = bit_ff + 4'h1;
          end else if (scl_fall) begin
            if (bit_ff == 4'h8) begin
              nxt_drv_low = 1'b0;
              nxt_st = THIMC_S_RACK;
              rd_byte_done = 1'b1; // RULE_18
            end else begin
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_drv_low = ~sh_ff[6];
            end
          end
        end
        THIMC_S_RACK: begin
          if (scl_rise) begin
            // host nack ends the read
            nxt_st = sda_s ? THIMC_S_IDLE : THIMC_S_AACK;
          end
        end
        default: nxt_st = THIMC_S_IDLE;
      endcase
    end
  end

  // pending data flag: set wins over clear by the host read
  always_comb begin
    nxt_init_int = init_int_ff;
    nxt_int_pend = int_pend_ff;
    if (rd_byte_done) begin
      nxt_int_pend = 1'b0; // RULE_18
      nxt_init_int = 1'b0;
    end
    if (!init_done_ff && nxt_init_done) begin
      nxt_init_int = 1'b1; // RULE_15
    end
    if (touch_valid_i && init_done_ff && mode_ff == THIMC_ACTIVE) begin
      nxt_int_pend = 1'b1; // RULE_06 RULE_16
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= THIMC_S_IDLE;
      sh_ff <= 8'h00;
      bit_ff <= 4'h0;
      rd_ff <= 1'b0;
      first_ff <= 1'b0;
      idx_ff <= 3'h0;
      drv_low_ff <= 1'b0;
      cfg_wr_ff <= '0;
      touch_rd_ff <= 1'b0;
      int_pend_ff <= 1'b0;
      init_int_ff <= 1'b0;
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg_ff[i] <= (i == int'(CFG_IDX_RATE)) ? RATE_RST : CFG_RST;
      end
    end else if (chip_rst) begin
      st_ff <= THIMC_S_IDLE;
      drv_low_ff <= 1'b0;
      cfg_wr_ff <= '0;
      touch_rd_ff <= 1'b0;
      int_pend_ff <= 1'b0;
      init_int_ff <= 1'b0;
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg_ff[i] <= (i == int'(CFG_IDX_RATE)) ? RATE_RST : CFG_RST;
      end
    end else begin
      st_ff <= nxt_st;
      sh_ff <= nxt_sh;
      bit_ff <= nxt_bit;
      rd_ff <= nxt_rd;
      first_ff <= nxt_first;
      idx_ff <= nxt_idx;
      drv_low_ff <= nxt_drv_low;
      cfg_wr_ff <= nxt_cfg_wr;
      touch_rd_ff <= nxt_touch_rd;
      int_pend_ff <= nxt_int_pend;
      init_int_ff <= nxt_init_int;
      cfg_ff <= nxt_cfg;
    end
  end

  // open-drain data pin; clock pin never driven
  assign sda_o = 1'b0; // RULE_09
  assign sda_oe_n_o = ~drv_low_ff;
  assign int_n_o = ~(int_pend_ff | init_int_ff); // RULE_06
  assign touch_rd_o = touch_rd_ff;
  assign mode_o = mode_ff;
  // rate clamped to the legal span
  assign frame_rate_o = (cfg_ff[CFG_IDX_RATE] > RATE_MAX) ?
    RATE_MAX : cfg_ff[CFG_IDX_RATE]; // RULE_01 RULE_02
  assign presence_only_o = (mode_ff == THIMC_MONITOR); // RULE_03
  assign scan_en_o = (mode_ff == THIMC_ACTIVE) & init_done_ff; // RULE_01
  assign cfg_wr_o = cfg_wr_ff;
endmodule : thimc_ctrl
`default_nettype wire

// ---- verif/thimc_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// host bus master; bus clock stands high between frames
module thimc_host_model (
  input wire logic sda_oe_n_i,
  input wire logic sda_val_i,
  output logic scl_o,
  output logic sda_o
);
  logic m_low = 1'b0;
  initial scl_o = 1'b1;
  // wired-and of both pull-downs over the pull-up
  assign sda_o = !m_low && (sda_oe_n_i || sda_val_i);
  // start or repeated start; long setup lets the device let go
  task automatic start;
    // step off the device clock edge so pin changes never race sampling
    #5;
    m_low = 1'b0;
    #80;
    scl_o = 1'b1;
    #40;
    m_low = 1'b1;
    #40;
    scl_o = 1'b0;
  endtask : start
  // stop closes the frame
  task automatic stop;
    m_low = 1'b1;
    #80;
    scl_o = 1'b1;
    #40;
    m_low = 1'b0;
    #80;
  endtask : stop
  // one 160 ns slot, line sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    #40;
    m_low = !b;
    #40;
    scl_o = 1'b1;
    #80;
    r = sda_o;
    scl_o = 1'b0;
  endtask : bit_io
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic a,
    output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(a, k);
  endtask : xfer
endmodule : thimc_host_model
`default_nettype wire

// ---- verif/thimc_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
// mode and port checks
module thimc_sva import thimc_pkg::*; #(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int IDLE_CYCLES = IDLE_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic host_reset_wake_n_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic int_n_o,
  input wire logic touch_valid_i,
  input wire logic presence_i,
  input wire logic touch_rd_o,
  input wire logic [1:0] mode_o,
  input wire logic [7:0] frame_rate_o,
  input wire logic presence_only_o,
  input wire thimc_cfg_wr_t cfg_wr_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // wake pin held low
  sequence s_pin_low;
    !host_reset_wake_n_i [*5];
  endsequence
  // touch seen while monitoring
  sequence s_mon_touch;
    mode_o == THIMC_MONITOR && presence_i;
  endsequence
  a_rate_max: assert property (frame_rate_o <= RATE_MAX)
    else $error("frame rate above limit");
  a_wake_touch: assert property (s_mon_touch |-> ##[1:4]
    mode_o == THIMC_ACTIVE) else $error("no wake on touch");
  a_only_mon: assert property (presence_only_o ==
    (mode_o == THIMC_MONITOR)) else $error("presence flag wrong");
  a_mon_quiet: assert property (mode_o == THIMC_MONITOR [*2]
    |-> sda_oe_n_o) else $error("bus driven in monitor");
  a_sleep_deaf: assert property (mode_o == THIMC_SLEEP |=>
    !cfg_wr_o.valid && !touch_rd_o) else $error("activity in sleep");
  a_touch_int: assert property (touch_valid_i &&
    mode_o == THIMC_ACTIVE |-> ##[1:3] !int_n_o) else $error("no irq");
  a_pin_reset: assert property (s_pin_low |->
    mode_o == THIMC_ACTIVE && int_n_o) else $error("pin reset failed");
  a_open_drain: assert property (!sda_oe_n_o |-> !sda_o)
    else $error("data pin driven high");
  a_cfg_pulse: assert property (cfg_wr_o.valid |=>
    !cfg_wr_o.valid) else $error("config pulse too long");
endmodule : thimc_sva
bind thimc_ctrl thimc_sva #(.INIT_CYCLES(INIT_CYCLES),
  .IDLE_CYCLES(IDLE_CYCLES)) u_sva (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .host_reset_wake_n_i(host_reset_wake_n_i),
  .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .int_n_o(int_n_o),
  .touch_valid_i(touch_valid_i), .presence_i(presence_i),
  .touch_rd_o(touch_rd_o), .mode_o(mode_o), .frame_rate_o(frame_rate_o),
  .presence_only_o(presence_only_o), .cfg_wr_o(cfg_wr_o));
`default_nettype wire

// ---- verif/touch_host_i2c_mode_ctrl_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module touch_host_i2c_mode_ctrl_bench import thimc_pkg::*; ;
  localparam int INIT_N = 20;
  localparam int IDLE_N = 3000;
  localparam logic [7:0] AW = {SLAVE_ADDR_RST, 1'b0};
  localparam logic [7:0] AR = {SLAVE_ADDR_RST, 1'b1};
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin_n = 1'b1;
  logic tv = 1'b0;
  logic pres = 1'b0;
  logic [7:0] tb = 8'hA5;
  wire scl, sda, sda_v, sda_oe_n, int_n, touch_rd, pres_only, scan_en;
  wire [1:0] mode;
  wire [7:0] rate;
  thimc_cfg_wr_t cfg, last_cfg;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_loads = 0;
  always #10 core_clk_i = ~core_clk_i;
  thimc_ctrl #(.INIT_CYCLES(INIT_N), .IDLE_CYCLES(IDLE_N)) u_thimc_ctrl (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .host_reset_wake_n_i(pin_n),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_v), .sda_oe_n_o(sda_oe_n),
    .int_n_o(int_n), .frame_done_i(1'b0), .touch_valid_i(tv),
    .touch_byte_i(tb), .presence_i(pres), .touch_rd_o(touch_rd),
    .mode_o(mode), .frame_rate_o(rate), .presence_only_o(pres_only),
    .scan_en_o(scan_en), .cfg_wr_o(cfg));
  thimc_host_model host (.sda_oe_n_i(sda_oe_n), .sda_val_i(sda_v),
    .scl_o(scl), .sda_o(sda));
  // last forwarded config byte, and the hang guard
  always @(posedge core_clk_i) begin
    if (cfg.valid === 1'b1) last_cfg <= cfg;
    if (touch_rd === 1'b1) n_loads <= n_loads + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
    input string m);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : tick
  // one byte, acknowledge compared with expectation
  task automatic wb(input logic [7:0] d, input logic ok);
    logic [7:0] r;
    logic k;
    host.xfer(d, 1'b1, r, k);
    chk({7'h00, k}, {7'h00, !ok}, "ack slot");
  endtask : wb
  task automatic wr(input logic [7:0] a, i, d, input logic ok);
    host.start();
    wb(a, ok);
    wb(i, ok);
    wb(d, ok);
    host.stop();
    tick(4);
  endtask : wr
  // read one byte then refuse more
  task automatic rd(input logic [7:0] exp);
    logic [7:0] r;
    logic k;
    host.start();
    wb(AR, 1'b1);
    host.xfer(8'hFF, 1'b1, r, k);
    chk(r, exp, "read byte");
    host.stop();
    tick(4);
  endtask : rd
  task automatic t_boot;
    chk({6'h00, mode}, {6'h00, THIMC_ACTIVE}, "mode at boot");
    chk(rate, RATE_RST, "rate at boot");
    chk({7'h00, int_n}, 8'h01, "irq before init");
    tick(INIT_N + 8);
    chk({7'h00, int_n}, 8'h00, "init irq");
    chk({7'h00, scan_en}, 8'h01, "scanning");
  endtask : t_boot
  task automatic t_write;
    wr(AW, {5'h00, CFG_IDX_RATE}, 8'h50, 1'b1);
    chk(rate, 8'h50, "new rate");
    chk(last_cfg.data, 8'h50, "forwarded data");
    chk({5'h00, last_cfg.idx}, 8'h00, "forwarded index");
    wr(AW, 8'h00, 8'hFF, 1'b1);
    chk(rate, RATE_MAX, "clamped rate");
    wr({7'h21, 1'b0}, 8'h00, 8'h10, 1'b0);
    chk(rate, RATE_MAX, "foreign address");
  endtask : t_write
  task automatic t_read;
    rd(8'hA5);
    chk({7'h00, int_n}, 8'h01, "irq released");
    @(posedge core_clk_i);
    tv <= 1'b1;
    @(posedge core_clk_i);
    tv <= 1'b0;
    tick(4);
    chk({7'h00, int_n}, 8'h00, "touch irq");
    host.start();
    wb(AW, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h10, 1'b1);
    rd(8'hA5);
    chk(rate, 8'h10, "rate before restart");
    chk({7'h00, int_n}, 8'h01, "irq after restart");
    chk(8'(n_loads), 8'h02, "one load per read byte");
  endtask : t_read
  task automatic t_monitor;
    int w;
    w = 0;
    while (mode !== THIMC_MONITOR && w < IDLE_N + 500) begin
      tick(1);
      w++;
    end
    chk({6'h00, mode}, {6'h00, THIMC_MONITOR}, "idle");
    chk({7'h00, pres_only}, 8'h01, "presence only");
    wr(AW, 8'h00, 8'h20, 1'b0);
    chk(rate, 8'h10, "closed port");
    @(posedge core_clk_i);
    pres <= 1'b1;
    tick(6);
    pres <= 1'b0;
    chk({6'h00, mode}, {6'h00, THIMC_ACTIVE}, "woken");
  endtask : t_monitor
  task automatic t_sleep;
    // sleep closes the port before the data byte acknowledge is sampled
    host.start();
    wb(AW, 1'b1);
    wb({5'h00, CFG_IDX_SLEEP}, 1'b1);
    wb(8'h01, 1'b0);
    host.stop();
    tick(4);
    chk({6'h00, mode}, {6'h00, THIMC_SLEEP}, "asleep");
    wr(AW, 8'h00, 8'h30, 1'b0);
    chk(rate, 8'h10, "deaf in sleep");
    @(posedge core_clk_i);
    pin_n <= 1'b0;
    tick(5);
    pin_n <= 1'b1;
    tick(4);
    chk({6'h00, mode}, {6'h00, THIMC_ACTIVE}, "pin wake");
    chk(rate, RATE_RST, "chip reset");
    tick(INIT_N + 8);
    chk({7'h00, int_n}, 8'h00, "init irq again");
  endtask : t_sleep
  // bus stays quiet until reset is over
  initial begin
    tick(8);
    rst_i <= 1'b0;
    tick(4);
    t_boot();
    t_write();
    t_read();
    t_monitor();
    t_sleep();
    end_sim();
  end
endmodule : touch_host_i2c_mode_ctrl_bench
`default_nettype wire
